// ==== hdl/mifwd_pkg.sv ====
// Constants and types shared by the interrupt message forwarder
package mifwd_pkg;
	// Register byte offsets on the APB slave
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] VEC_OFS = 12'h008;
	// Control and status bit positions, reset values
	localparam int CTRL_REMAP_BIT = 0;
	localparam int CTRL_CLUSTER_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int STAT_PEND_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam logic [7:0] VEC_RST = 8'h00;
	// Interrupt address window and field positions
	localparam logic [11:0] MSI_ADDR_TAG = 12'hFEE;
	localparam int ADDR_HINT_BIT = 3;
	localparam int ADDR_DMODE_BIT = 2;
	// Redirection entry field positions
	localparam int ENT_DEST_LSB = 56;
	localparam int ENT_EID_LSB = 48;
	localparam int ENT_TRIG_BIT = 15;
	localparam int ENT_DMODE_BIT = 11;
	// Interrupt data field positions and codes
	localparam int DATA_TRIG_BIT = 15;
	localparam int DATA_STATUS_BIT = 14;
	localparam int DATA_DMODE_BIT = 11;
	localparam logic [2:0] DLV_LOWEST_PRI = 3'h1;
	// Remap table entry is 16 bytes
	localparam int REMAP_SHIFT = 4;
	// Kinds of traffic arriving from the downstream ports
	typedef enum logic [1:0] {KIND_WRITE = 2'h0, KIND_WIRE = 2'h1, KIND_REPLY = 2'h2} mifwd_kind_t;
	// Where the held item is headed
	typedef enum logic [3:0] {
		DST_GOP = 4'b0001,
		DST_PL = 4'b0010,
		DST_REMAP = 4'b0100,
		DST_CPL = 4'b1000
	} mifwd_dst_t;
	// Vector fetch tracking
	typedef enum logic [1:0] {ACK_IDLE = 2'b01, ACK_WAIT = 2'b10} mifwd_ack_t;
endpackage

// ==== hdl/mifwd_top.sv ====
// Interrupt message forwarder: ordering, vector fetch relay, interrupt word decode
`timescale 1ns/1ps
module mifwd_top
(
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic PREADY_O,
	output logic [31:0] PRDATA_O,
	output logic PSLVERR_O,
	input wire logic DN_VALID_I,
	output logic DN_READY_O,
	input wire mifwd_pkg::mifwd_kind_t DN_KIND_I,
	input wire logic [31:0] DN_ADDR_I,
	input wire logic [31:0] DN_DATA_I,
	input wire logic ENT_VALID_I,
	output logic ENT_READY_O,
	input wire logic [63:0] ENT_I,
	input wire logic HF_REQ_I,
	output logic LEGACY_ACK_REQ_O,
	output logic HF_CPL_VALID_O,
	output logic [7:0] HF_CPL_VECTOR_O,
	output logic [31:0] OUT_ADDR_O,
	output logic [31:0] OUT_DATA_O,
	output logic GOP_VALID_O,
	output logic GOP_WIRE_O,
	input wire logic GOP_READY_I,
	output logic PL_VALID_O,
	output logic PL_LOGICAL_O,
	output logic PL_HINT_O,
	output logic [31:0] PL_TARGET_O,
	input wire logic PL_READY_I,
	output logic REMAP_VALID_O,
	output logic [31:0] REMAP_OFS_O,
	input wire logic REMAP_READY_I
);
	import mifwd_pkg::*;
	// Build interrupt address from a redirection entry
	function automatic logic [31:0] build_addr(input logic [63:0] e);
		logic hint;
		hint = (e[10:8] == DLV_LOWEST_PRI);
		build_addr = {MSI_ADDR_TAG, e[ENT_DEST_LSB+:8], e[ENT_EID_LSB+:8],
			hint, e[ENT_DMODE_BIT], 2'b00};
	endfunction
	// Build interrupt data from a redirection entry
	function automatic logic [31:0] build_data(input logic [63:0] e);
		build_data = {16'h0000, e[ENT_TRIG_BIT], 1'b1, 2'b00,
			e[ENT_DMODE_BIT], e[10:0]};
	endfunction
	// Lowest set bit of a mask, the simple redirection choice
	function automatic logic [7:0] low_bit(input logic [7:0] m);
		low_bit = m & (~m + 8'h01);
	endfunction

	// Processor target id from address and mode
	function automatic logic [31:0] target_of(input logic [31:0] a, input logic clu);
		logic [7:0] d;
		logic [3:0] c;
		d = a[19:12];
		c = a[15:12];
		target_of = 32'h0000_0000;
		if (!a[ADDR_DMODE_BIT])
			target_of[7:0] = d;
		else if (clu)
		begin
			// Hint narrows the cluster mask to one member
			d = low_bit({4'h0, c});
			target_of[19:16] = a[19:16];
			target_of[3:0] = a[ADDR_HINT_BIT] ? d[3:0] : c;
		end
		else
			target_of[7:0] = a[ADDR_HINT_BIT] ? low_bit(d) : d;
	endfunction

	logic [1:0] ctrl_q, ctrl_d;
	logic err_q, err_d;
	logic [31:0] rdata_q, rdata_d;
	mifwd_ack_t ack_q, ack_d;
	logic ack_req_q, ack_req_d;
	logic cpl_q, cpl_d;
	logic [7:0] vec_q, vec_d;
	logic st_valid_q, st_valid_d;
	mifwd_dst_t st_dst_q, st_dst_d;
	logic st_wire_q, st_wire_d;
	logic [31:0] st_addr_q, st_addr_d;
	logic [31:0] st_data_q, st_data_d;
	logic [31:0] st_tgt_q, st_tgt_d;
	logic st_leave, in_take, dn_take, ent_take;
	logic [31:0] in_addr, in_data;
	logic [16:0] handle;
	logic wr_acc, bad_addr;

	// Single in-order holding stage; nothing overtakes the held item
	assign st_leave = st_valid_q && ((st_dst_q == DST_GOP && GOP_READY_I)
		|| (st_dst_q == DST_PL && PL_READY_I)
		|| (st_dst_q == DST_REMAP && REMAP_READY_I) || st_dst_q == DST_CPL);
	assign DN_READY_O = !st_valid_q || st_leave;
	assign ENT_READY_O = DN_READY_O && !DN_VALID_I;
	assign dn_take = DN_VALID_I && DN_READY_O;
	assign ent_take = ENT_VALID_I && ENT_READY_O;
	assign in_take = dn_take || ent_take;
	assign in_addr = dn_take ? DN_ADDR_I : build_addr(ENT_I);
	assign in_data = dn_take ? DN_DATA_I : build_data(ENT_I);
	assign handle = {1'b0, in_addr[19:4]} + (in_addr[ADDR_HINT_BIT] ? {1'b0, in_data[15:0]} : 17'h0);

	// Classify and shape the incoming item
	always_comb
	begin
		st_valid_d = st_valid_q;
		st_dst_d = st_dst_q;
		st_wire_d = st_wire_q;
		st_addr_d = st_addr_q;
		st_data_d = st_data_q;
		st_tgt_d = st_tgt_q;
		if (st_leave)
			st_valid_d = 1'b0;
		if (in_take)
		begin
			st_valid_d = 1'b1;
			st_addr_d = in_addr;
			st_data_d = in_data;
			st_wire_d = dn_take && DN_KIND_I == KIND_WIRE;
			st_tgt_d = 32'h0000_0000;
			if (dn_take && DN_KIND_I == KIND_REPLY)
				st_dst_d = DST_CPL;
			else if (dn_take && DN_KIND_I == KIND_WIRE)
				st_dst_d = DST_GOP;
			else if (in_addr[31:20] != MSI_ADDR_TAG || in_addr[1:0] != 2'b00)
				st_dst_d = DST_GOP;
			else if (ctrl_q[CTRL_REMAP_BIT])
			begin
				st_dst_d = DST_REMAP;
				st_tgt_d = {11'h000, handle, 4'h0};
			end
			else
			begin
				st_dst_d = DST_PL;
				st_data_d[DATA_DMODE_BIT] = 1'b0;
				st_tgt_d = target_of(in_addr, ctrl_q[CTRL_CLUSTER_BIT]);
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			st_valid_q <= 1'b0;
			st_dst_q <= DST_GOP;
			st_wire_q <= 1'b0;
			st_addr_q <= 32'h0000_0000;
			st_data_q <= 32'h0000_0000;
			st_tgt_q <= 32'h0000_0000;
		end
		else
		begin
			st_valid_q <= st_valid_d;
			st_dst_q <= st_dst_d;
			st_wire_q <= st_wire_d;
			st_addr_q <= st_addr_d;
			st_data_q <= st_data_d;
			st_tgt_q <= st_tgt_d;
		end
	end
	// Stage outputs, all from flops
	assign OUT_ADDR_O = st_addr_q;
	assign OUT_DATA_O = st_data_q;
	assign GOP_VALID_O = st_valid_q && st_dst_q == DST_GOP;
	assign GOP_WIRE_O = st_wire_q;
	assign PL_VALID_O = st_valid_q && st_dst_q == DST_PL;
	assign PL_LOGICAL_O = st_addr_q[ADDR_DMODE_BIT];
	assign PL_HINT_O = st_addr_q[ADDR_HINT_BIT];
	assign PL_TARGET_O = st_tgt_q;
	assign REMAP_VALID_O = st_valid_q && st_dst_q == DST_REMAP;
	assign REMAP_OFS_O = st_tgt_q;

	// Vector fetch relay; a second fetch or stray reply is flagged, not served
	always_comb
	begin
		ack_d = ack_q;
		ack_req_d = 1'b0;
		cpl_d = 1'b0;
		vec_d = vec_q;
		unique case (ack_q)
			ACK_IDLE:
			begin
				if (HF_REQ_I)
				begin
					ack_req_d = 1'b1;
					ack_d = ACK_WAIT;
				end
			end
			ACK_WAIT:
			begin
				if (st_leave && st_dst_q == DST_CPL)
				begin
					cpl_d = 1'b1;
					vec_d = st_data_q[7:0];
					ack_d = ACK_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ack_q <= ACK_IDLE;
			ack_req_q <= 1'b0;
			cpl_q <= 1'b0;
			vec_q <= VEC_RST;
		end
		else
		begin
			ack_q <= ack_d;
			ack_req_q <= ack_req_d;
			cpl_q <= cpl_d;
			vec_q <= vec_d;
		end
	end

	assign LEGACY_ACK_REQ_O = ack_req_q;
	assign HF_CPL_VALID_O = cpl_q;
	assign HF_CPL_VECTOR_O = vec_q;

	// APB slave: zero wait, read data captured in setup phase
	assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
	assign bad_addr = PADDR_I != CTRL_OFS && PADDR_I != STAT_OFS && PADDR_I != VEC_OFS;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && bad_addr;
	assign PRDATA_O = rdata_q;

	always_comb
	begin
		ctrl_d = ctrl_q;
		rdata_d = rdata_q;
		// Set wins over a write-one clear in the same cycle
		err_d = err_q;
		if (wr_acc && PADDR_I == STAT_OFS && PWDATA_I[STAT_ERR_BIT])
			err_d = 1'b0;
		if ((HF_REQ_I && ack_q == ACK_WAIT)
			|| (st_leave && st_dst_q == DST_CPL && ack_q == ACK_IDLE))
			err_d = 1'b1;
		if (wr_acc && PADDR_I == CTRL_OFS)
			ctrl_d = PWDATA_I[1:0];
		if (PSEL_I && !PENABLE_I)
		begin
			rdata_d = 32'h0000_0000;
			if (PADDR_I == CTRL_OFS)
				rdata_d[1:0] = ctrl_q;
			else if (PADDR_I == STAT_OFS)
				rdata_d[1:0] = {err_q, ack_q == ACK_WAIT};
			else if (PADDR_I == VEC_OFS)
				rdata_d[7:0] = vec_q;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ctrl_q <= CTRL_RST;
			err_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			err_q <= err_d;
			rdata_q <= rdata_d;
		end
	end
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_fetch;
		HF_REQ_I && ack_q == ACK_IDLE;
	endsequence
	sequence s_reply_out;
		st_leave && st_dst_q == DST_CPL && ack_q == ACK_WAIT;
	endsequence

	a_fetch_relay: assert property (s_fetch |=> LEGACY_ACK_REQ_O && !HF_CPL_VALID_O)
		else $error("fetch did not raise acknowledge request");
	a_reply_vector: assert property (s_reply_out |=> HF_CPL_VALID_O
		&& HF_CPL_VECTOR_O == $past(st_data_q[7:0]))
		else $error("completion vector wrong or missing");
	a_stage_blocks: assert property (st_valid_q && !st_leave |-> !DN_READY_O
		##1 st_valid_q && $stable(st_addr_q))
		else $error("held item overtaken");
	a_phys_target: assert property (PL_VALID_O && !PL_LOGICAL_O |-> PL_TARGET_O[31:8] == 24'h0
		&& PL_TARGET_O[7:0] == OUT_ADDR_O[19:12])
		else $error("physical target wrong");
	a_dmode_clear: assert property (PL_VALID_O |-> !OUT_DATA_O[DATA_DMODE_BIT])
		else $error("destination mode bit forwarded");
	a_entry_words: assert property (ent_take && !ctrl_q[CTRL_REMAP_BIT] |=> st_data_q[31:16] == 16'h0
		&& st_data_q[DATA_STATUS_BIT] && st_data_q[13:12] == 2'b00
		&& st_data_q[DATA_TRIG_BIT] == $past(ENT_I[ENT_TRIG_BIT])
		&& st_data_q[10:0] == $past(ENT_I[10:0]))
		else $error("built data word wrong");
	a_entry_hint: assert property (ent_take |=> st_addr_q[ADDR_HINT_BIT] == ($past(ENT_I[10:8])
		== DLV_LOWEST_PRI) && st_addr_q[19:12] == $past(ENT_I[63:56]))
		else $error("built address wrong");
	a_plain_write: assert property (dn_take && DN_KIND_I == KIND_WRITE
		&& DN_ADDR_I[31:20] != MSI_ADDR_TAG |=> GOP_VALID_O && !GOP_WIRE_O)
		else $error("plain write misrouted");
	a_remap_ofs: assert property (REMAP_VALID_O |-> REMAP_OFS_O[31:4] == {11'h000, {1'b0,
		OUT_ADDR_O[19:4]} + (OUT_ADDR_O[ADDR_HINT_BIT] ? {1'b0, OUT_DATA_O[15:0]} : 17'h00000)}
		&& REMAP_OFS_O[3:0] == 4'h0)
		else $error("remap offset wrong");
	a_flat_copy: assert property (PL_VALID_O && PL_LOGICAL_O && !PL_HINT_O
		&& !ctrl_q[CTRL_CLUSTER_BIT] && $stable(ctrl_q) |-> PL_TARGET_O[7:0] == OUT_ADDR_O[19:12])
		else $error("flat target wrong");
endmodule

// ==== testbench/mifwd_far_model.sv ====
// Far side: processor sockets fetching vectors, plus the link sinks
`timescale 1ns/1ps
module mifwd_far_model
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic fetch_i,
	input wire logic stall_i,
	input wire logic cpl_i,
	output logic hf_req_o,
	output logic ready_o
);
	logic busy_q;
	logic tick_q;
	// A second fetch is held back until the completion, never issued twice
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			busy_q <= 1'b0;
			tick_q <= 1'b0;
			hf_req_o <= 1'b0;
		end
		else
		begin
			hf_req_o <= fetch_i && !busy_q;
			busy_q <= (busy_q || fetch_i) && !cpl_i;
			tick_q <= ~tick_q;
		end
	end
	// Slow mode accepts only every other cycle, so the stage has to hold
	assign ready_o = !stall_i || tick_q;
endmodule

// ==== testbench/mifwd_top_tb.sv ====
// Self-checking bench for the interrupt message forwarder
`timescale 1ns/1ps
module mifwd_top_tb;
	import mifwd_pkg::*;
	typedef struct packed {logic [1:0] k; logic [31:0] a; logic [31:0] d; logic [31:0] t;
		logic [2:0] f;} mifwd_rec_t;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rdata, dn_addr = 32'h0, dn_data = 32'h0, prdata, o_addr, o_data;
	logic [31:0] pl_tgt, remap_ofs;
	logic dn_valid = 1'b0, ent_valid = 1'b0, fetch = 1'b0, stall = 1'b0;
	logic hf_req, rdy, pready, pslverr, dn_ready, ent_ready, ack_req, cpl_v;
	logic gop_v, gop_wire, pl_v, pl_log, pl_hint, remap_v;
	mifwd_kind_t dn_kind = KIND_WRITE;
	logic [63:0] ent = 64'h0;
	logic [7:0] cpl_vec, last_vec;
	int errors = 0, n_tests = 0, acks = 0, cpls = 0, cpl_order = 0;
	mifwd_rec_t seen[$];
	always #50 clk = ~clk;
	mifwd_top DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
		.PRDATA_O(prdata), .PSLVERR_O(pslverr), .DN_VALID_I(dn_valid), .DN_READY_O(dn_ready),
		.DN_KIND_I(dn_kind), .DN_ADDR_I(dn_addr), .DN_DATA_I(dn_data), .ENT_VALID_I(ent_valid),
		.ENT_READY_O(ent_ready), .ENT_I(ent), .HF_REQ_I(hf_req), .LEGACY_ACK_REQ_O(ack_req),
		.HF_CPL_VALID_O(cpl_v), .HF_CPL_VECTOR_O(cpl_vec), .OUT_ADDR_O(o_addr),
		.OUT_DATA_O(o_data), .GOP_VALID_O(gop_v), .GOP_WIRE_O(gop_wire), .GOP_READY_I(rdy),
		.PL_VALID_O(pl_v), .PL_LOGICAL_O(pl_log), .PL_HINT_O(pl_hint), .PL_TARGET_O(pl_tgt),
		.PL_READY_I(rdy), .REMAP_VALID_O(remap_v), .REMAP_OFS_O(remap_ofs), .REMAP_READY_I(rdy));
	mifwd_far_model far (.clk_i(clk), .rst_n_i(rst_n), .fetch_i(fetch), .stall_i(stall),
		.cpl_i(cpl_v), .hf_req_o(hf_req), .ready_o(rdy));
	// Log every item except replies at the edge where it leaves, so stalls cannot hide order
	always @(posedge clk)
	begin
		if (ack_req === 1'b1)
			acks++;
		if (cpl_v === 1'b1)
		begin
			cpls++;
			last_vec = cpl_vec;
			cpl_order = seen.size();
		end
		if (gop_v === 1'b1 && rdy === 1'b1)
			seen.push_back({2'd0, o_addr, o_data, 32'h0, 2'b00, gop_wire});
		if (pl_v === 1'b1 && rdy === 1'b1)
			seen.push_back({2'd1, o_addr, o_data, pl_tgt, pl_hint, pl_log, 1'b0});
		if (remap_v === 1'b1 && rdy === 1'b1)
			seen.push_back({2'd2, o_addr, o_data, remap_ofs, 3'b000});
	end
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons=%0d mismatches=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic hang();
		errors++;
		$display("CHECK FAILED t=%0t got=%h exp=%h (wait ran out)", $time, 0, 1);
		finish_test();
	endtask
	// APB master: setup, then access until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Access phase ends at the edge where pready is seen high
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
			hang();
		rdata = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic send(input mifwd_kind_t k, input logic use_ent, input logic [63:0] e);
		int i;
		@(posedge clk);
		if (use_ent)
		begin
			ent_valid <= 1'b1;
			ent <= e;
		end
		else
		begin
			dn_valid <= 1'b1;
			dn_kind <= k;
			{dn_addr, dn_data} <= e;
		end
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if ((use_ent ? ent_ready : dn_ready) === 1'b1)
				break;
		end
		if (i == 50)
			hang();
		dn_valid <= 1'b0;
		ent_valid <= 1'b0;
	endtask
	task automatic take(output mifwd_rec_t r);
		for (int i = 0; i < 50 && seen.size() == 0; i++)
			@(negedge clk);
		if (seen.size() == 0)
			hang();
		r = seen.pop_front();
	endtask
	task automatic wait_cnt(ref int c, input int n);
		for (int i = 0; i < 100 && c < n; i++)
			@(negedge clk);
		if (c < n)
			hang();
	endtask
	task automatic one(input logic use_ent, input logic [63:0] e, input mifwd_rec_t x,
		input logic ofs_only);
		mifwd_rec_t r;
		send(KIND_WRITE, use_ent, e);
		take(r);
		chk(ofs_only ? {r.k, r.t} : r, ofs_only ? {x.k, x.t} : x);
	endtask
	task automatic t_regs();
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rdata, CTRL_RST);
		apb(1'b0, VEC_OFS, 32'h0);
		chk(rdata, VEC_RST);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdata, 32'h0);
		apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
		apb(1'b0, 12'h00C, 32'h0);
		chk({slv, rdata}, {1'b1, 32'h0});
		apb(1'b1, CTRL_OFS, 32'h3);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rdata, 32'h3);
		apb(1'b1, CTRL_OFS, 32'h0);
		$display("registers done");
	endtask
	task automatic t_order();
		mifwd_rec_t r;
		@(posedge clk);
		stall <= 1'b1;
		send(KIND_WRITE, 1'b0, {32'h0000_4000, 32'h1});
		send(KIND_WIRE, 1'b0, {32'h0, 32'h0});
		take(r);
		chk({r.k, r.a, r.f}, {2'd0, 32'h0000_4000, 3'b000});
		take(r);
		chk({r.k, r.f}, {2'd0, 3'b001});
		@(posedge clk);
		stall <= 1'b0;
		$display("ordering done");
	endtask
	task automatic t_fetch();
		mifwd_rec_t r;
		@(posedge clk);
		stall <= 1'b1;
		@(posedge clk);
		fetch <= 1'b1;
		@(posedge clk);
		fetch <= 1'b0;
		wait_cnt(acks, 1);
		chk(cpls, 0);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdata, 32'h0000_0001);
		send(KIND_WRITE, 1'b0, {32'h0000_1000, 32'h7});
		send(KIND_REPLY, 1'b0, {32'h0, 32'h0000_00A5});
		wait_cnt(cpls, 1);
		chk({acks, last_vec}, {32'd1, 8'hA5});
		chk(cpl_order, 1);
		take(r);
		chk(r.a, 32'h0000_1000);
		@(posedge clk);
		stall <= 1'b0;
		apb(1'b0, VEC_OFS, 32'h0);
		chk(rdata, 32'h0000_00A5);
		// A reply nobody asked for is dropped and flagged, the vector kept
		send(KIND_REPLY, 1'b0, {32'h0, 32'h0000_005A});
		apb(1'b0, VEC_OFS, 32'h0);
		chk({cpls, rdata}, {32'd1, 32'h0000_00A5});
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdata, 32'h0000_0002);
		apb(1'b1, STAT_OFS, 32'h0000_0002);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdata, 32'h0);
		$display("vector fetch done");
	endtask
	task automatic t_plain();
		one(0, {32'h1234_5678, 32'hCAFE_0001}, {2'd0, 32'h1234_5678, 32'hCAFE_0001, 35'h0}, 0);
		one(0, {32'hFEE0_0001, 32'h5}, {2'd0, 32'hFEE0_0001, 32'h5, 32'h0, 3'h0}, 0);
		$display("plain writes done");
	endtask
	task automatic t_target();
		one(0, {32'hFEE1_2340, 32'h4831}, {2'd1, 32'hFEE1_2340, 32'h4031, 32'h12, 3'h0}, 0);
		one(0, {32'hFEEA_B004, 32'h22}, {2'd1, 32'hFEEA_B004, 32'h22, 32'hAB, 3'h2}, 0);
		one(0, {32'hFEE0_C00C, 32'h100}, {2'd1, 32'hFEE0_C00C, 32'h100, 32'h04, 3'h6}, 0);
		apb(1'b1, CTRL_OFS, 32'h2);
		one(0, {32'hFEE5_A004, 32'h22}, {2'd1, 32'hFEE5_A004, 32'h22, 32'h5_000A, 3'h2}, 0);
		one(0, {32'hFEE3_600C, 32'h22}, {2'd1, 32'hFEE3_600C, 32'h22, 32'h3_0002, 3'h6}, 0);
		apb(1'b1, CTRL_OFS, 32'h0);
		$display("target ids done");
	endtask
	task automatic t_entry();
		// Entry sweep over every delivery mode; odd modes go logical flat
		for (int m = 0; m < 8; m++)
			one(1, {8'h3C, 8'h5D, 32'h0, 1'b1, 3'b111, m[0], m[2:0], 8'h40 + 8'(m)},
				{2'd1, 12'hFEE, 8'h3C, 8'h5D, m == 1, m[0], 2'b00,
				16'h0, 4'b1100, 1'b0, m[2:0], 8'h40 + 8'(m),
				(m == 1) ? 32'h04 : 32'h3C, m == 1, m[0], 1'b0}, 0);
		$display("entry words done");
	endtask
	task automatic t_remap();
		apb(1'b1, CTRL_OFS, 32'h1);
		one(0, {32'hFEE1_2348, 32'h10}, {2'd2, 64'h0, 32'h0001_2440, 3'h0}, 1);
		one(0, {32'hFEE0_0050, 32'hFFFF}, {2'd2, 64'h0, 32'h50, 3'h0}, 1);
		apb(1'b1, CTRL_OFS, 32'h0);
		$display("remap offsets done");
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_plain();
		t_order();
		t_target();
		t_entry();
		t_remap();
		t_fetch();
		finish_test();
	end
endmodule
